// ---- tsfs_pkg.sv ----
// constants and types shared by the timing source fallback selector
`default_nettype none
package tsfs_pkg;
  // clocking and line rates
  localparam int CORE_CLK_HZ  = 50_000_000;
  localparam int CORE_CLK_NS  = 20;
  localparam int LINE_RATE_HZ = 2_048_000;
  localparam int INT_HALF_CYC = CORE_CLK_HZ / (2 * LINE_RATE_HZ);
  localparam int LOS_TIME_NS  = 2000;
  localparam int LOS_CYC      = LOS_TIME_NS / CORE_CLK_NS;
  localparam int CNT_W        = 8;
  localparam logic [CNT_W-1:0] INT_HALF_LAST = CNT_W'(INT_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] LOS_LAST      = CNT_W'(LOS_CYC);
  localparam int OSC_PPM      = 32;

  // link count and frame alignment figures
  localparam int NUM_LINKS        = 4;
  localparam int FAS_WINDOW       = 5;
  localparam int FAS_DECLARE_ERRS = 3;
  localparam int FAS_CLEAR_GOOD   = 2;

  // timing source codes
  localparam logic [2:0] SRC_INTERNAL = 3'h0;
  localparam logic [2:0] SRC_STATION  = 3'h1;
  localparam logic [2:0] SRC_LINK0    = 3'h2;
  localparam logic [2:0] SRC_NONE     = 3'h7;

  // register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 12'h00C;

  // control fields
  localparam int CTRL_MAIN_LSB = 0;
  localparam int CTRL_FB_LSB   = 4;
  localparam int CTRL_RTX_BIT  = 8;

  // status fields
  localparam int ST_ACT_LSB      = 0;
  localparam int ST_LOF_LSB      = 4;
  localparam int ST_DEAD_LSB     = 8;
  localparam int ST_STN_DEAD_BIT = 12;
  localparam int ST_SWITCH_BIT   = 13;

  // interrupt event bits
  localparam int EV_W        = 8;
  localparam int EV_SWITCH   = 0;
  localparam int EV_MAIN_BAD = 1;
  localparam int EV_STN_LOST = 2;
  localparam int EV_LOF_LSB  = 4;

  typedef enum logic [1:0] {MUX_FOLLOW, MUX_PARK, MUX_WAIT} tsfs_mux_st_t;
endpackage
`default_nettype wire

// ---- tsfs_fas_mon.sv ----
// frame alignment loss monitor for one receive link
`default_nettype none
module tsfs_fas_mon (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // frame results
  input  wire logic frame_stb,
  input  wire logic fas_err,
  // state
  output logic      lof_q
);
  logic [tsfs_pkg::FAS_WINDOW-1:0] hist_q, hist_d;
  logic [1:0]                      good_q, good_d;
  logic                            lof_d;

  function automatic int err_count(input logic [tsfs_pkg::FAS_WINDOW-1:0] h);
    int n;
    n = 0;
    for (int i = 0; i < tsfs_pkg::FAS_WINDOW; i++) begin
      n = n + int'(h[i]);
    end
    return n;
  endfunction

  always_comb begin
    hist_d = hist_q;
    good_d = good_q;
    lof_d  = lof_q;
    if (frame_stb) begin
      hist_d = {hist_q[tsfs_pkg::FAS_WINDOW-2:0], fas_err};
      if (fas_err) begin
        good_d = 2'h0;
      end else if (int'(good_q) < tsfs_pkg::FAS_CLEAR_GOOD) begin
        good_d = good_q + 2'h1;
      end
      if (!lof_q && err_count(hist_d) >= tsfs_pkg::FAS_DECLARE_ERRS) begin
        lof_d = 1'b1; // [RULE12]
      end else if (lof_q && int'(good_d) == tsfs_pkg::FAS_CLEAR_GOOD) begin
        lof_d  = 1'b0; // [RULE13]
        hist_d = '0;
      end
    end
  end

  // a link counts as unaligned until two clean frames are seen
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hist_q <= '0;
      good_q <= 2'h0;
      lof_q  <= 1'b1;
    end else begin
      hist_q <= hist_d;
      good_q <= good_d;
      lof_q  <= lof_d;
    end
  end
endmodule
`default_nettype wire

// ---- tsfs_top.sv ----
// system timing source selector with main and fallback switching
// Contract
// RULE1: with no usable fallback, a failed reference moves timing to internal oscillator.
// RULE2: loss of sync on the main link counts as main reference failure.
// RULE3: a configured healthy fallback is adopted when the main reference fails.
// RULE4: if the fallback has also failed, timing reverts to the internal oscillator.
// RULE5: when the main reference recovers it becomes active again automatically.
// RULE6: each link receive path runs on that link's own recovered clock.
// RULE7: far end uses loopback or external timing from the same reference.
// RULE8: station input takes framed or unframed all-ones at 2.048 Mbps and locks.
// RULE9: returned-clock mode supplies clocks and samples tx data on the returned clock.
// RULE10: loopback timing locks the system clock to one selected link's recovered clock.
// RULE11: internal timing comes from a free-running 32 ppm crystal oscillator.
// RULE12: loss of frame alignment when 3 or 4 errors in last 5 frames.
// RULE13: loss of frame alignment clears after two consecutive error-free frames.
// RULE14: source changes make no runt pulses; active source is readable status.
// RULE15: main and fallback are separate settings; an empty fallback means internal.
//
// Implementation choices: register access over APB and the register offsets.
`default_nettype none
module tsfs_top #(
  parameter int NL = tsfs_pkg::NUM_LINKS
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  // apb slave
  input  wire logic [tsfs_pkg::ADDR_W-1:0] paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // e1 receive side
  input  wire logic [NL-1:0]               link_rx_clk,
  input  wire logic [NL-1:0]               link_frame_mark,
  input  wire logic [NL-1:0]               link_fas_err,
  // station reference
  input  wire logic                        station_clk,
  // user channel
  input  wire logic                        user_ext_tx_clk,
  input  wire logic                        user_tx_data,
  output logic                             user_rx_clk,
  output logic                             user_tx_clk,
  output logic                             user_tx_data_smp,
  // timing outputs
  output logic                             sys_ref_clk,
  output logic      [2:0]                  active_src,
  output logic                             irq
);
  localparam int NP     = 3 * NL + 3;
  localparam int P_MARK = NL;
  localparam int P_FAS  = 2 * NL;
  localparam int P_STN  = 3 * NL;
  localparam int P_ETX  = 3 * NL + 1;
  localparam int P_TXD  = 3 * NL + 2;

  // pin synchronisers; s1 feeds only s2
  logic [NP-1:0] s1_q, s2_q, s3_q, rise;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {user_tx_data, user_ext_tx_clk, station_clk, link_fas_err, link_frame_mark,
               link_rx_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q & ~s3_q;

  // clock activity watch on each link and the station input
  logic [tsfs_pkg::CNT_W-1:0] los_cnt_q [NL+1];
  logic [tsfs_pkg::CNT_W-1:0] los_cnt_d [NL+1];
  logic [NL:0]                dead;
  logic [NL-1:0]              lof;
  genvar gi;
  generate
    for (gi = 0; gi <= NL; gi++) begin : g_act
      localparam int B = (gi < NL) ? gi : P_STN;
      always_comb begin
        if (rise[B]) begin
          los_cnt_d[gi] = '0;
        end else if (los_cnt_q[gi] == tsfs_pkg::LOS_LAST) begin
          los_cnt_d[gi] = los_cnt_q[gi];
        end else begin
          los_cnt_d[gi] = los_cnt_q[gi] + 1'b1;
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          los_cnt_q[gi] <= tsfs_pkg::LOS_LAST;
        end else begin
          los_cnt_q[gi] <= los_cnt_d[gi];
        end
      end
      // framing is irrelevant here, so framed and unframed all-ones both lock
      assign dead[gi] = (los_cnt_q[gi] == tsfs_pkg::LOS_LAST); // [RULE8]
    end
    for (gi = 0; gi < NL; gi++) begin : g_fas
      // frames are strobed only on this link's own recovered clock edges
      tsfs_fas_mon u_mon (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .frame_stb (rise[gi] & s2_q[P_MARK + gi]), // [RULE6]
        .fas_err   (s2_q[P_FAS + gi]),
        .lof_q     (lof[gi])
      );
    end
  endgenerate

  // internal free-running reference, divided from the crystal-fed core clock
  logic [tsfs_pkg::CNT_W-1:0] int_cnt_q, int_cnt_d;
  logic                       int_clk_q, int_clk_d;
  always_comb begin
    int_cnt_d = int_cnt_q + 1'b1;
    int_clk_d = int_clk_q;
    if (int_cnt_q == tsfs_pkg::INT_HALF_LAST) begin
      int_cnt_d = '0;
      int_clk_d = ~int_clk_q; // [RULE11]
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      int_cnt_q <= '0;
      int_clk_q <= 1'b0;
    end else begin
      int_cnt_q <= int_cnt_d;
      int_clk_q <= int_clk_d;
    end
  end

  function automatic logic src_level(input logic [2:0] s, input logic [NP-1:0] lv,
                                     input logic ic);
    logic r;
    r = ic;
    if (s == tsfs_pkg::SRC_STATION) begin
      r = lv[P_STN];
    end else if (s >= tsfs_pkg::SRC_LINK0 && int'(s - tsfs_pkg::SRC_LINK0) < NL) begin
      r = lv[s - tsfs_pkg::SRC_LINK0]; // [RULE10]
    end
    return r;
  endfunction

  function automatic logic src_ok(input logic [2:0] s, input logic [NL:0] bad);
    logic r;
    r = 1'b0;
    if (s == tsfs_pkg::SRC_INTERNAL) begin
      r = 1'b1;
    end else if (s == tsfs_pkg::SRC_STATION) begin
      r = !bad[NL];
    end else if (s >= tsfs_pkg::SRC_LINK0 && int'(s - tsfs_pkg::SRC_LINK0) < NL) begin
      r = !bad[s - tsfs_pkg::SRC_LINK0];
    end
    return r;
  endfunction

  // configuration
  logic [2:0] main_q, main_d, fb_q, fb_d;
  logic       rtx_q, rtx_d;
  logic [NL:0] bad;
  logic [2:0]  want;
  logic        main_ok;
  assign bad     = {dead[NL], dead[NL-1:0] | lof}; // [RULE2]
  assign main_ok = src_ok(main_q, bad);

  always_comb begin
    if (main_ok) begin
      want = main_q; // [RULE5]
    end else if (fb_q != tsfs_pkg::SRC_NONE && src_ok(fb_q, bad)) begin
      want = fb_q; // [RULE3] [RULE15]
    end else begin
      want = tsfs_pkg::SRC_INTERNAL; // [RULE1] [RULE4]
    end
  end

  // glitch-free reference switch: park low on the old source, join the new one while low
  tsfs_pkg::tsfs_mux_st_t     st_q, st_d;
  logic [2:0]                 act_q, act_d, tgt_q, tgt_d;
  logic                       ref_q, ref_d, ref_prev_q;
  logic [tsfs_pkg::CNT_W-1:0] park_q, park_d;
  logic                       cur_lv, tgt_lv, switched;
  assign cur_lv = src_level(act_q, s2_q, int_clk_q);
  assign tgt_lv = src_level(tgt_q, s2_q, int_clk_q);

  always_comb begin
    st_d     = st_q;
    act_d    = act_q;
    tgt_d    = tgt_q;
    ref_d    = 1'b0;
    park_d   = park_q;
    switched = 1'b0;
    case (st_q)
      tsfs_pkg::MUX_FOLLOW: begin
        ref_d = cur_lv;
        if (want != act_q) begin
          tgt_d  = want;
          park_d = '0;
          st_d   = tsfs_pkg::MUX_PARK;
        end
      end
      tsfs_pkg::MUX_PARK: begin
        // a dead source may be stuck high, so the wait for its fall is bounded
        if (!cur_lv || park_q == tsfs_pkg::LOS_LAST) begin
          st_d = tsfs_pkg::MUX_WAIT; // [RULE14]
        end else begin
          ref_d  = cur_lv;
          park_d = park_q + 1'b1;
        end
      end
      tsfs_pkg::MUX_WAIT: begin
        tgt_d = want;
        if (!tgt_lv && want == tgt_q) begin
          act_d    = tgt_q; // [RULE14]
          switched = 1'b1;
          st_d     = tsfs_pkg::MUX_FOLLOW;
        end
      end
      default: begin
        st_d = tsfs_pkg::MUX_FOLLOW;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q       <= tsfs_pkg::MUX_FOLLOW;
      act_q      <= tsfs_pkg::SRC_INTERNAL;
      tgt_q      <= tsfs_pkg::SRC_INTERNAL;
      ref_q      <= 1'b0;
      ref_prev_q <= 1'b0;
      park_q     <= '0;
    end else begin
      st_q       <= st_d;
      act_q      <= act_d;
      tgt_q      <= tgt_d;
      ref_q      <= ref_d;
      ref_prev_q <= ref_q;
      park_q     <= park_d;
    end
  end

  // user transmit data capture on our own or the returned transmit clock
  logic txd_q, txd_d, tx_edge;
  assign tx_edge = rtx_q ? rise[P_ETX] : (ref_q & ~ref_prev_q); // [RULE9]
  assign txd_d   = tx_edge ? s2_q[P_TXD] : txd_q;

  // interrupt events
  logic [tsfs_pkg::EV_W-1:0] ev, ist_q, ist_d, imask_q, imask_d, w1c;
  logic [NL-1:0]             lof_prev_q;
  logic                      main_ok_prev_q, stn_dead_prev_q, irq_q;
  always_comb begin
    ev = '0;
    ev[tsfs_pkg::EV_SWITCH]   = switched;
    ev[tsfs_pkg::EV_MAIN_BAD] = main_ok_prev_q & ~main_ok;
    ev[tsfs_pkg::EV_STN_LOST] = dead[NL] & ~stn_dead_prev_q;
    ev[tsfs_pkg::EV_LOF_LSB +: NL] = lof & ~lof_prev_q;
  end
  // a new event in the clearing cycle stays set
  assign ist_d = (ist_q & ~w1c) | ev;

  // apb slave: one wait cycle, then pready for one cycle
  function automatic logic is_mapped(input logic [tsfs_pkg::ADDR_W-1:0] a);
    return a == tsfs_pkg::ADDR_CTRL || a == tsfs_pkg::ADDR_STATUS ||
           a == tsfs_pkg::ADDR_INT_STAT || a == tsfs_pkg::ADDR_INT_MASK;
  endfunction

  logic [31:0] prdata_q, prdata_d, rd_val;
  logic        pready_q, pready_d, pslverr_q, pslverr_d, wr_en;
  always_comb begin
    rd_val = '0;
    case (paddr)
      tsfs_pkg::ADDR_CTRL: begin
        rd_val[tsfs_pkg::CTRL_MAIN_LSB +: 3] = main_q;
        rd_val[tsfs_pkg::CTRL_FB_LSB +: 3]   = fb_q;
        rd_val[tsfs_pkg::CTRL_RTX_BIT]       = rtx_q;
      end
      tsfs_pkg::ADDR_STATUS: begin
        rd_val[tsfs_pkg::ST_ACT_LSB +: 3]    = act_q; // [RULE14]
        rd_val[tsfs_pkg::ST_LOF_LSB +: NL]   = lof;
        rd_val[tsfs_pkg::ST_DEAD_LSB +: NL]  = dead[NL-1:0];
        rd_val[tsfs_pkg::ST_STN_DEAD_BIT]    = dead[NL];
        rd_val[tsfs_pkg::ST_SWITCH_BIT]      = (st_q != tsfs_pkg::MUX_FOLLOW);
      end
      tsfs_pkg::ADDR_INT_STAT: rd_val[tsfs_pkg::EV_W-1:0] = ist_q;
      tsfs_pkg::ADDR_INT_MASK: rd_val[tsfs_pkg::EV_W-1:0] = imask_q;
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (psel && penable && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = !is_mapped(paddr);
      prdata_d  = pwrite ? prdata_q : rd_val;
    end
    wr_en   = psel && penable && pready_q && pwrite;
    main_d  = main_q;
    fb_d    = fb_q;
    rtx_d   = rtx_q;
    imask_d = imask_q;
    w1c     = '0;
    if (wr_en && paddr == tsfs_pkg::ADDR_CTRL) begin
      main_d = pwdata[tsfs_pkg::CTRL_MAIN_LSB +: 3];
      fb_d   = pwdata[tsfs_pkg::CTRL_FB_LSB +: 3];
      rtx_d  = pwdata[tsfs_pkg::CTRL_RTX_BIT];
    end
    if (wr_en && paddr == tsfs_pkg::ADDR_INT_STAT) begin
      w1c = pwdata[tsfs_pkg::EV_W-1:0];
    end
    if (wr_en && paddr == tsfs_pkg::ADDR_INT_MASK) begin
      imask_d = pwdata[tsfs_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      main_q          <= tsfs_pkg::SRC_INTERNAL;
      fb_q            <= tsfs_pkg::SRC_NONE;
      rtx_q           <= 1'b0;
      imask_q         <= '0;
      ist_q           <= '0;
      irq_q           <= 1'b0;
      lof_prev_q      <= '1;
      main_ok_prev_q  <= 1'b1;
      stn_dead_prev_q <= 1'b1;
      prdata_q        <= '0;
      pready_q        <= 1'b0;
      pslverr_q       <= 1'b0;
      txd_q           <= 1'b0;
    end else begin
      main_q          <= main_d;
      fb_q            <= fb_d;
      rtx_q           <= rtx_d;
      imask_q         <= imask_d;
      ist_q           <= ist_d;
      irq_q           <= |(ist_d & imask_d);
      lof_prev_q      <= lof;
      main_ok_prev_q  <= main_ok;
      stn_dead_prev_q <= dead[NL];
      prdata_q        <= prdata_d;
      pready_q        <= pready_d;
      pslverr_q       <= pslverr_d;
      txd_q           <= txd_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign sys_ref_clk      = ref_q;
  assign user_rx_clk      = ref_q; // [RULE9]
  assign user_tx_clk      = ref_q;
  assign user_tx_data_smp = txd_q;
  assign active_src       = act_q;
  assign irq              = irq_q;
endmodule
`default_nettype wire

// ---- tsfs_checker.sv ----
// port assertions for the timing source selector
`default_nettype none
module tsfs_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // timing outputs
  input wire logic        sys_ref_clk,
  input wire logic        user_rx_clk,
  input wire logic        user_tx_clk,
  input wire logic [2:0]  active_src
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missed its cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  refused_read_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("bad refused access");
  src_code_a: assert property (active_src <= 3'h5)
    else $error("active source code out of range");
  // a change while high would cut the running pulse short
  switch_low_a: assert property ($changed(active_src) |-> !sys_ref_clk && !$past(sys_ref_clk))
    else $error("source changed while clock high");
  no_runt_a: assert property ($rose(sys_ref_clk) |=> sys_ref_clk [*2])
    else $error("runt high pulse");
  user_clk_a: assert property (user_rx_clk == sys_ref_clk && user_tx_clk == sys_ref_clk)
    else $error("user clocks not from system clock");
  internal_half_a: assert property ($rose(sys_ref_clk) && active_src == 3'h0 |->
    sys_ref_clk [*8] ##5 !sys_ref_clk)
    else $error("internal half period wrong");
endmodule

bind tsfs_top tsfs_checker chk_u (
  .core_clk    (core_clk),
  .nrst        (nrst),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .sys_ref_clk (sys_ref_clk),
  .user_rx_clk (user_rx_clk),
  .user_tx_clk (user_tx_clk),
  .active_src  (active_src)
);
`default_nettype wire

// ---- tsfs_line_model.sv ----
// model of the e1 line interfaces and the station clock source
`default_nettype none
module tsfs_line_model (
  // bench controls
  input  wire logic [3:0] link_on,
  input  wire logic [3:0] err_on,
  input  wire logic       stn_on,
  // line side
  output logic      [3:0] link_rx_clk,
  output logic      [3:0] link_frame_mark,
  output logic      [3:0] link_fas_err,
  output logic            station_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       line_clk = 1'b0;
  logic       stn_clk  = 1'b0;
  logic [2:0] bit_cnt  = 3'h0;
  // all links come from one network source, as the far end loops timing
  always #80 line_clk = ~line_clk;
  always #244 stn_clk = ~stn_clk;
  always @(negedge line_clk) bit_cnt <= bit_cnt + 3'h1;
  // 8-bit frames keep the run short; frame length is not counted inside
  always_comb begin
    link_rx_clk     = {4{line_clk}} & link_on;
    link_frame_mark = (bit_cnt == 3'h7) ? link_on : 4'h0;
    link_fas_err    = (bit_cnt == 3'h7) ? err_on : ~err_on;
    station_clk     = stn_clk & stn_on;
  end
endmodule
`default_nettype wire

// ---- timing_source_fallback_select_bench.sv ----
// self-checking bench for the timing source selector
`default_nettype none
module timing_source_fallback_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = 32'h0;
  logic [3:0]  link_on  = 4'hF;
  logic [3:0]  err_on   = 4'h0;
  logic        stn_on   = 1'b1;
  logic        ext_clk  = 1'b0;
  logic        tx_data  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  rx_clk;
  logic [3:0]  mark;
  logic [3:0]  fas;
  logic        stn_clk;
  logic        tx_smp;
  logic        irq;
  logic [2:0]  active_src;
  logic [31:0] rd;
  logic        slv;
  logic [2:0]  m;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          seed        = 32'h0436;

  always #10 core_clk = ~core_clk;

  tsfs_line_model line_u (.link_on(link_on), .err_on(err_on), .stn_on(stn_on),
    .link_rx_clk(rx_clk), .link_frame_mark(mark), .link_fas_err(fas), .station_clk(stn_clk));

  tsfs_top dut_u (.core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_rx_clk(rx_clk), .link_frame_mark(mark), .link_fas_err(fas),
    .station_clk(stn_clk), .user_ext_tx_clk(ext_clk), .user_tx_data(tx_data),
    .user_rx_clk(), .user_tx_clk(), .user_tx_data_smp(tx_smp), .sys_ref_clk(),
    .active_src(active_src), .irq(irq));

  function automatic logic [31:0] ctrl_word(input logic [2:0] mn, input logic [2:0] fb,
                                            input logic rt);
    return {23'h0, rt, 1'b0, fb, 1'b0, mn};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a hung access
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // polls with a bound, then confirms through the status register
  task automatic wait_src(input logic [2:0] exp);
    int n;
    n = 0;
    while (active_src !== exp && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    check({29'h0, active_src}, {29'h0, exp});
    apb(1'b0, tsfs_pkg::ADDR_STATUS, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, exp});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #1ms;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    check({29'h0, active_src}, 32'h0);
    nrst <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, tsfs_pkg::ADDR_CTRL, 32'h0);
    check(rd, ctrl_word(tsfs_pkg::SRC_INTERNAL, tsfs_pkg::SRC_NONE, 1'b0));
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    check({31'h0, slv}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, slv}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, tsfs_pkg::ADDR_INT_MASK, 32'h1);
    $display("test reset done");
    apb(1'b1, tsfs_pkg::ADDR_CTRL, ctrl_word(3'h3, tsfs_pkg::SRC_STATION, 1'b0));
    wait_src(tsfs_pkg::SRC_LINK0 + 3'h1);
    check({31'h0, irq}, 32'h1);
    err_on <= 4'h2;
    wait_src(tsfs_pkg::SRC_STATION);
    check({31'h0, rd[tsfs_pkg::ST_LOF_LSB+1]}, 32'h1);
    stn_on <= 1'b0;
    wait_src(tsfs_pkg::SRC_INTERNAL);
    apb(1'b1, tsfs_pkg::ADDR_INT_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, tsfs_pkg::ADDR_INT_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, tsfs_pkg::ADDR_INT_STAT, 32'h1);
    check({31'h0, irq}, 32'h0);
    err_on <= 4'h0;
    wait_src(tsfs_pkg::SRC_LINK0 + 3'h1);
    $display("test fallback done");
    stn_on <= 1'b1;
    apb(1'b1, tsfs_pkg::ADDR_CTRL, ctrl_word(tsfs_pkg::SRC_STATION, tsfs_pkg::SRC_NONE, 1'b0));
    wait_src(tsfs_pkg::SRC_STATION);
    stn_on <= 1'b0;
    wait_src(tsfs_pkg::SRC_INTERNAL);
    stn_on <= 1'b1;
    $display("test empty fallback done");
    repeat (6) begin
      m = 3'($unsigned($random(seed)) % 6);
      apb(1'b1, tsfs_pkg::ADDR_CTRL, ctrl_word(m, 3'($unsigned($random(seed)) % 6), 1'b0));
      wait_src(m);
    end
    $display("test random select done");
    apb(1'b1, tsfs_pkg::ADDR_CTRL, ctrl_word(tsfs_pkg::SRC_INTERNAL, tsfs_pkg::SRC_NONE, 1'b1));
    tx_data <= 1'b1;
    repeat (60) @(posedge core_clk);
    check({31'h0, tx_smp}, 32'h0);
    ext_clk <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({31'h0, tx_smp}, 32'h1);
    apb(1'b1, tsfs_pkg::ADDR_CTRL, ctrl_word(tsfs_pkg::SRC_INTERNAL, tsfs_pkg::SRC_NONE, 1'b0));
    tx_data <= 1'b0;
    repeat (60) @(posedge core_clk);
    check({31'h0, tx_smp}, 32'h0);
    $display("test returned clock done");
    wrap_up();
  end
endmodule
`default_nettype wire
